// File: rtl/psc_pkg.sv
// Constants and carrier types for the pipeline stage sequencer.
`default_nettype none
package psc_pkg;
	// Stage slots: front end 1-6, microcode fetch F and T, back end 7-10.
	localparam int PSC_NSTG = 12;
	localparam int PSC_S1 = 0;
	localparam int PSC_S2 = 1;
	localparam int PSC_S3 = 2;
	localparam int PSC_S4 = 3;
	localparam int PSC_S5 = 4;
	localparam int PSC_S6 = 5;
	localparam int PSC_SF = 6;
	localparam int PSC_ST = 7;
	localparam int PSC_S7 = 8;
	localparam int PSC_S8 = 9;
	localparam int PSC_S9 = 10;
	localparam int PSC_S10 = 11;
	localparam int PSC_FRONT_LAST = PSC_S6;
	localparam int PSC_NONE = PSC_NSTG;
	// Slots that run in odd beats (stages 1,3,5,F,7,9).
	localparam logic [11:0] PSC_ODD_MASK = 12'h555;
	localparam logic [11:0] PSC_EVEN_MASK = 12'haaa;
	localparam logic [11:0] PSC_FRONT_MASK = 12'h03f;
	localparam logic [11:0] PSC_FRONT_ODD = 12'h015;
	localparam logic [11:0] PSC_NO_STAGES = 12'h000;
	// One beat is two ticks of the 10 ns system clock.
	localparam int PSC_TICKS_PER_BEAT = 2;
	localparam int PSC_CLK_PERIOD_NS = 10;
	localparam int PSC_BEAT_NS = PSC_TICKS_PER_BEAT * PSC_CLK_PERIOD_NS;
	localparam logic PSC_PH_FIRST = 1'b0;
	localparam logic PSC_PH_LAST = 1'b1;

	typedef logic [PSC_NSTG-1:0] psc_stage_vec_t;

	// Conditions from the instruction, storage, execution and store units.
	typedef struct packed
	{
		logic start;
		logic mispredict_flush;
		logic step_terminal;
		logic mem_wait;
		logic unaligned_read;
		logic arith_extend;
		logic even_extend;
		logic reg_collision;
		logic mem_trap;
		logic overlap_late;
		logic conditional_return_to_fetch;
	} psc_hold_t;
endpackage : psc_pkg
`default_nettype wire

// File: rtl/psc_stage_sequencer.sv
// Stage sequencer: active flags, hold collection and stage clock enables.
// Functional notes
// RULE1: Five instructions in flight, alternating odd/even beats; one enters every two beats.
// RULE2: Non-terminal microstep stops front-end advance until a terminal step.
// RULE3: Odd-address 32-bit read cycles cache twice, one beat penalty.
// RULE4: Stage 7 loads incremented address; stage 8 reads second part.
// RULE5: Arithmetic extension holds whole pipeline one beat.
// RULE6: Active, unheld stage drives its clock enable.
// RULE7: Front end may hold while back end keeps stepping microcode.
// RULE8: Misprediction flush clears the front end and refills.
// RULE9: An extension request holds all even stages together.
// RULE10: Stage 6 overlap with stage 8 is selectable.
// RULE11: Idle microsteps go to execution while front end refills.
// RULE12: Memory wait suspends all stage clocking.
// RULE13: Register collision separates instructions in the front end.
// RULE14: Memory trap holds fetch stage while older instructions finish.
// RULE15: Enables for stages 1-5 and initial stage; stage 6 clock from latter.
// RULE16: Front-end stage clocks occur once per instruction.
// RULE17: Microaddress clock every odd beat except conditional return sequences.
// RULE18: Microword load follows microaddress and accompanies stage 6 clock.
// RULE19: Back-end enables repeat once per microstep.
// RULE20: Active set at stage start; unheld stage clocks and clears at beat end.
// RULE21: Held stage keeps its active flag and withholds its clock.
// RULE22: A beat lasts two system clock ticks.
// RULE23: Reset forces every active flag inactive.
// RULE24: Stage clock is registered enable, one pulse per completed stage.
`default_nettype none
module psc_stage_sequencer
	import psc_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Conditions from surrounding units.
	input wire psc_pkg::psc_hold_t hold_in,
	// Stage enables and completion clocks, one bit per slot.
	output psc_pkg::psc_stage_vec_t stage_enable,
	output psc_pkg::psc_stage_vec_t stage_clock,
	// Side effects of sequencing.
	output logic idle_microstep,
	output logic addr_autoinc,
	output logic second_part_read,
	output logic odd_beat
);
	import psc_pkg::*;

	if (PSC_TICKS_PER_BEAT != 2)
	begin : g_beat_check
		$error("psc_stage_sequencer supports two ticks per beat only");
	end

	// Successor slot that a completing stage hands its work to.
	function automatic int psc_succ(input int idx);
		case (idx)
			PSC_S6: psc_succ = PSC_S7;
			PSC_SF: psc_succ = PSC_ST;
			PSC_ST: psc_succ = PSC_S7;
			PSC_S10: psc_succ = PSC_NONE;
			default: psc_succ = idx + 1;
		endcase
	endfunction : psc_succ

	logic ph_ff;
	logic odd_ff;
	logic run_ff;
	logic refill_ff;
	logic una_ff;
	logic ext_ff;
	logic frz_ff;
	logic autoinc_ff;
	logic second_ff;
	psc_stage_vec_t act_ff;
	psc_stage_vec_t en_ff;
	psc_stage_vec_t clk_ff;
	psc_stage_vec_t hold;
	psc_stage_vec_t nxt_en;
	psc_stage_vec_t nxt_act;
	logic beat_end;
	logic global_hold;
	logic flush;

	assign beat_end = (ph_ff == PSC_PH_LAST);
	assign flush = hold_in.start | hold_in.mispredict_flush;
	// Whole-pipe suspensions.
	assign global_hold = hold_in.mem_wait // see RULE12
		| una_ff // see RULE3
		| ext_ff; // see RULE5

	// Two-tick beat timing and beat parity.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ph_ff <= PSC_PH_FIRST;
			odd_ff <= 1'b1;
		end
		else
		begin
			ph_ff <= ~ph_ff; // see RULE22
			if (beat_end && !frz_ff)
			begin
				odd_ff <= ~odd_ff; // see RULE1
			end
		end
	end

	// A globally held beat keeps its parity, so the penalty stays one beat
	// and the stages that were held run in the very next beat.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frz_ff <= 1'b0;
		end
		else if (!beat_end)
		begin
			frz_ff <= global_hold; // see RULE3 see RULE5
		end
	end

	// Hold collection per slot.
	always_comb
	begin
		hold = {PSC_NSTG{global_hold}};
		hold = hold | (odd_ff ? PSC_EVEN_MASK : PSC_ODD_MASK);
		if (hold_in.even_extend)
		begin
			hold = hold | PSC_EVEN_MASK; // see RULE9
		end
		if (!hold_in.step_terminal)
		begin
			hold = hold | PSC_FRONT_MASK; // see RULE2 see RULE7
		end
		if (hold_in.reg_collision)
		begin
			hold = hold | PSC_FRONT_ODD; // see RULE13
		end
		hold[PSC_S1] = hold[PSC_S1] | hold_in.mem_trap; // see RULE14
		hold[PSC_S6] = hold[PSC_S6]
			| (hold_in.overlap_late & act_ff[PSC_S8]); // see RULE10
		hold[PSC_SF] = hold[PSC_SF]
			| hold_in.conditional_return_to_fetch; // see RULE17
		for (int i = 0; i < PSC_NSTG; i++)
		begin
			if (psc_succ(i) != PSC_NONE)
			begin
				hold[i] = hold[i] | act_ff[psc_succ(i)];
			end
		end
	end

	// Enables: active and not held; stage 6 also brings microword load.
	always_comb
	begin
		nxt_en = act_ff & ~hold; // see RULE6 see RULE15 see RULE19
		nxt_en[PSC_ST] = nxt_en[PSC_ST] | nxt_en[PSC_S6]; // see RULE18
	end

	// Enables are sampled in the first tick and stand for the whole beat.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			en_ff <= PSC_NO_STAGES;
		end
		else if (!beat_end)
		begin
			en_ff <= nxt_en;
		end
	end

	// Next active flags at beat end.
	always_comb
	begin
		nxt_act = act_ff & ~en_ff; // see RULE20 see RULE21
		for (int i = 0; i < PSC_NSTG; i++)
		begin
			if (en_ff[i] && psc_succ(i) != PSC_NONE)
			begin
				nxt_act[psc_succ(i)] = 1'b1;
			end
		end
		// New instruction and new microaddress enter while running.
		if (run_ff && en_ff[PSC_S1])
		begin
			nxt_act[PSC_S1] = 1'b1; // see RULE1 see RULE16
		end
		if (run_ff && en_ff[PSC_SF])
		begin
			nxt_act[PSC_SF] = 1'b1; // see RULE17
		end
		if (flush)
		begin
			nxt_act = (nxt_act & ~PSC_FRONT_MASK); // see RULE8
			nxt_act[PSC_S1] = 1'b1;
			nxt_act[PSC_SF] = 1'b1;
		end
	end

	// Stage active flags. Flush is taken only at beat end.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			act_ff <= PSC_NO_STAGES; // see RULE23
		end
		else if (beat_end)
		begin
			act_ff <= nxt_act;
		end
	end

	// Completion clocks: one tick after each beat end with enable.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			clk_ff <= PSC_NO_STAGES;
		end
		else
		begin
			clk_ff <= beat_end ? en_ff : PSC_NO_STAGES; // see RULE24
		end
	end

	// Run and refill state.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			run_ff <= 1'b0;
			refill_ff <= 1'b0;
		end
		else if (beat_end)
		begin
			if (flush)
			begin
				run_ff <= 1'b1;
				refill_ff <= 1'b1; // see RULE11
			end
			else if (en_ff[PSC_S6])
			begin
				refill_ff <= 1'b0;
			end
		end
	end

	// Unaligned read: second cache cycle costs one held beat.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			una_ff <= 1'b0;
			autoinc_ff <= 1'b0;
			second_ff <= 1'b0;
		end
		else
		begin
			autoinc_ff <= 1'b0;
			second_ff <= 1'b0;
			if (beat_end)
			begin
				if (una_ff)
				begin
					una_ff <= 1'b0;
					second_ff <= 1'b1; // see RULE4
				end
				else if (en_ff[PSC_S7] && hold_in.unaligned_read)
				begin
					una_ff <= 1'b1; // see RULE3
					autoinc_ff <= 1'b1; // see RULE4
				end
			end
		end
	end

	// Arithmetic extension: one extra beat for execution.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ext_ff <= 1'b0;
		end
		else if (beat_end)
		begin
			ext_ff <= ~ext_ff & act_ff[PSC_S8]
				& hold_in.arith_extend; // see RULE5
		end
	end

	assign stage_enable = en_ff;
	assign stage_clock = clk_ff;
	assign idle_microstep = refill_ff;
	assign addr_autoinc = autoinc_ff;
	assign second_part_read = second_ff;
	assign odd_beat = odd_ff;

	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	clock_after_beat_a: assert property ( // see RULE24
		(clk_ff != PSC_NO_STAGES) |-> $past(ph_ff) && clk_ff == $past(en_ff))
		else $error("stage clock not at beat end");
	beat_two_ticks_a: assert property ( // see RULE22
		beat_end |=> !beat_end ##1 beat_end)
		else $error("beat is not two ticks");
	parity_split_a: assert property ( // see RULE1
		!((en_ff & PSC_ODD_MASK) != 0 && (en_ff & PSC_EVEN_MASK) != 0))
		else $error("odd and even stages enabled together");
	mem_wait_stop_a: assert property ( // see RULE12
		(beat_end && $past(hold_in.mem_wait)) |-> en_ff == PSC_NO_STAGES)
		else $error("stage enabled during memory wait");
	front_stop_a: assert property ( // see RULE2
		(beat_end && !$past(hold_in.step_terminal))
		|-> (en_ff & PSC_FRONT_MASK) == PSC_NO_STAGES)
		else $error("front end advanced on non-terminal step");
	collision_sep_a: assert property ( // see RULE13
		(beat_end && $past(hold_in.reg_collision))
		|-> (en_ff & PSC_FRONT_ODD) == PSC_NO_STAGES)
		else $error("odd front stage enabled during collision");
	trap_hold_a: assert property ( // see RULE14
		(beat_end && $past(hold_in.mem_trap)) |-> !en_ff[PSC_S1])
		else $error("fetch stage advanced during trap");
	unaligned_seq_a: assert property ( // see RULE4
		autoinc_ff |-> ##2 second_part_read ##1 !una_ff)
		else $error("second operand part not read two ticks later");
	extend_hold_a: assert property ( // see RULE5
		(beat_end && $past(ext_ff)) |-> en_ff == PSC_NO_STAGES)
		else $error("pipeline not held during extension");
	load_with_s6_a: assert property ( // see RULE18
		en_ff[PSC_S6] |-> en_ff[PSC_ST])
		else $error("microword load missing at stage 6");
	held_stays_a: assert property ( // see RULE21
		(beat_end && !flush) |=>
		((act_ff & $past(act_ff & ~en_ff)) == $past(act_ff & ~en_ff)))
		else $error("held stage lost its active flag");
	even_ext_a: assert property ( // see RULE9
		(beat_end && $past(hold_in.even_extend))
		|-> (en_ff & PSC_EVEN_MASK) == PSC_NO_STAGES)
		else $error("even stage enabled during extension");
	overlap_hold_a: assert property ( // see RULE10
		(beat_end && $past(hold_in.overlap_late && act_ff[PSC_S8]))
		|-> !en_ff[PSC_S6])
		else $error("stage 6 enabled while stage 8 busy");

	unaligned_c: cover property (autoinc_ff ##2 second_part_read);
	extend_c: cover property (ext_ff ##[1:8] clk_ff[PSC_S8]);
	refill_c: cover property ($rose(refill_ff) ##[1:40] $fell(refill_ff));
	flush_c: cover property (beat_end && hold_in.mispredict_flush);
endmodule : psc_stage_sequencer
`default_nettype wire

// File: tb/psc_far_units.sv
// Far-side unit model that turns bench requests into sequencer conditions.
`default_nettype none
module psc_far_units
	import psc_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Bench requests and sequencer feedback.
	input wire psc_pkg::psc_hold_t req,
	input wire logic start_req,
	input wire logic addr_autoinc,
	// Conditions presented to the sequencer.
	output psc_pkg::psc_hold_t hold_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] start_cnt_ff;
	logic unal_done_ff;

	// Start stands a whole beat, so one beat end always sees it.
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			start_cnt_ff <= 2'h0;
		else if (start_req)
			start_cnt_ff <= 2'h2;
		else if (start_cnt_ff != 2'h0)
			start_cnt_ff <= start_cnt_ff - 2'h1;

	// The storage unit withdraws its report once the split read begins.
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			unal_done_ff <= 1'b0;
		else if (!req.unaligned_read)
			unal_done_ff <= 1'b0;
		else if (addr_autoinc)
			unal_done_ff <= 1'b1;

	always_comb
	begin
		hold_in = req;
		hold_in.start = start_cnt_ff != 2'h0;
		hold_in.unaligned_read = req.unaligned_read & ~unal_done_ff;
	end
endmodule : psc_far_units
`default_nettype wire

// File: tb/psc_stage_sequencer_tb.sv
// Self-checking bench for the pipeline stage sequencer.
`default_nettype none
module psc_stage_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import psc_pkg::*;
	logic clk;
	logic reset_n = 1'b0;
	logic start_req = 1'b0;
	psc_hold_t req = '0;
	psc_hold_t hold_in;
	psc_stage_vec_t stage_enable;
	psc_stage_vec_t stage_clock;
	psc_stage_vec_t en_prev = '0;
	psc_stage_vec_t cnt_mask = '0;
	psc_stage_vec_t exp_q[$];
	logic idle_microstep;
	logic addr_autoinc;
	logic second_part_read;
	logic odd_beat;
	logic ob1 = 1'b0;
	logic ob2 = 1'b0;
	logic ob_chk = 1'b0;
	int num_errors = 0;
	int check_count = 0;
	int pulse_cnt = 0;
	int seed = 56606;
	int rcnt = 0;
	int i;

	psc_stage_sequencer u_psc_stage_sequencer (.clk(clk), .reset_n(reset_n),
		.hold_in(hold_in), .stage_enable(stage_enable),
		.stage_clock(stage_clock), .idle_microstep(idle_microstep),
		.addr_autoinc(addr_autoinc), .second_part_read(second_part_read),
		.odd_beat(odd_beat));
	psc_far_units u_psc_far_units (.clk(clk), .reset_n(reset_n), .req(req),
		.start_req(start_req), .addr_autoinc(addr_autoinc),
		.hold_in(hold_in));

	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	function automatic psc_hold_t hw(input logic trap, input logic coll,
		input logic crtf, input logic term);
		hw = '{mem_trap: trap, reg_collision: coll, step_terminal: term,
			conditional_return_to_fetch: crtf, default: 1'b0};
	endfunction : hw

	// Outputs are sampled 1 ns after the edge, when they have settled.
	always @(posedge clk)
	begin
		#1;
		rcnt = reset_n ? rcnt + 1 : 0;
		if (rcnt > 0 && stage_clock !== 12'h000)
		begin
			check(stage_clock & ~(stage_enable | en_prev), 12'h000);
			if (exp_q.size() > 0)
				check(stage_clock, exp_q.pop_front());
			if ((stage_clock & cnt_mask) !== 12'h000)
				pulse_cnt++;
		end
		if (ob_chk && rcnt > 3)
			check({11'h000, odd_beat}, {11'h000, ~ob2});
		ob2 = ob1;
		ob1 = odd_beat;
		en_prev = stage_enable;
	end

	task automatic rst();
		@(negedge clk);
		reset_n = 1'b0;
		req = hw(1'b0, 1'b0, 1'b0, 1'b1);
		cnt_mask = '0;
		repeat (2) @(negedge clk);
		check(stage_enable | stage_clock, 12'h000);
		check({11'h000, odd_beat}, 12'h001);
		exp_q.delete();
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask : rst

	task automatic kick();
		start_req = 1'b1;
		@(negedge clk);
		start_req = 1'b0;
	endtask : kick

	task automatic drain();
		for (i = 0; i < 60 && exp_q.size() > 0; i++)
			@(negedge clk);
		check({11'h000, exp_q.size() > 0}, 12'h000);
	endtask : drain

	// Nominal fill from a start: five beats of stage clocks.
	task automatic flow();
		rst();
		exp_q.push_back(12'h041);
		exp_q.push_back(12'h082);
		exp_q.push_back(12'h145);
		exp_q.push_back(12'h28a);
		exp_q.push_back(12'h555);
		kick();
	endtask : flow

	task automatic run(input psc_hold_t h, input logic [11:0] e1,
		input logic [11:0] e2);
		rst();
		req = h;
		exp_q.push_back(e1);
		exp_q.push_back(e2);
		kick();
		drain();
	endtask : run

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		#100000;
		num_errors++;
		end_sim();
	end

	initial
	begin
		ob_chk = 1'b1;
		run(hw(1'b0, 1'b0, 1'b0, 1'b1), 12'h041, 12'h082);
		ob_chk = 1'b0;
		run(hw(1'b0, 1'b0, 1'b0, 1'b0), 12'h040, 12'h080);
		run(hw(1'b1, 1'b0, 1'b0, 1'b1), 12'h040, 12'h080);
		run(hw(1'b0, 1'b1, 1'b0, 1'b1), 12'h040, 12'h080);
		run(hw(1'b0, 1'b0, 1'b1, 1'b1), 12'h001, 12'h002);
		// Everything stays frozen for a random number of beats.
		rst();
		req.mem_wait = 1'b1;
		cnt_mask = 12'hfff;
		pulse_cnt = 0;
		kick();
		repeat (4 + 2 * ($random(seed) & 3)) @(negedge clk);
		check(pulse_cnt[11:0], 12'h000);
		exp_q.push_back(12'h041);
		req.mem_wait = 1'b0;
		drain();
		rst();
		req.even_extend = 1'b1;
		cnt_mask = PSC_EVEN_MASK;
		pulse_cnt = 0;
		exp_q.push_back(12'h041);
		kick();
		drain();
		repeat (10) @(negedge clk);
		check(pulse_cnt[11:0], 12'h000);
		rst();
		req.unaligned_read = 1'b1;
		kick();
		for (i = 0; i < 80 && addr_autoinc !== 1'b1; i++)
			@(posedge clk) #1;
		check({11'h000, addr_autoinc}, 12'h001);
		@(posedge clk) #1;
		check({11'h000, second_part_read}, 12'h000);
		@(posedge clk) #1;
		check({11'h000, second_part_read}, 12'h001);
		check(stage_enable, 12'h000);
		@(posedge clk) #1;
		check(stage_enable, 12'h28a);
		// Arithmetic extension costs exactly one beat before the next wave.
		flow();
		req.arith_extend = 1'b1;
		for (i = 0; i < 80 && stage_clock !== 12'h28a; i++)
			@(posedge clk) #1;
		repeat (4) @(posedge clk) #1;
		check(stage_clock, 12'h555);
		drain();
		// A late overlap keeps stage 6 back while stage 8 is busy.
		flow();
		req.overlap_late = 1'b1;
		exp_q.push_back(12'ha8a);
		drain();
		rst();
		kick();
		repeat (4) @(negedge clk);
		check({11'h000, idle_microstep}, 12'h001);
		for (i = 0; i < 80 && stage_clock[PSC_S6] !== 1'b1; i++)
			@(posedge clk) #1;
		check({11'h000, stage_clock[PSC_ST]}, 12'h001);
		repeat (2) @(negedge clk);
		check({11'h000, idle_microstep}, 12'h000);
		req.mispredict_flush = 1'b1;
		repeat (2) @(negedge clk);
		req.mispredict_flush = 1'b0;
		repeat (2) @(negedge clk);
		check({11'h000, idle_microstep}, 12'h001);
		end_sim();
	end
endmodule : psc_stage_sequencer_tb
`default_nettype wire
